// *** common/wdt_defines.vh ***
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
// Register byte offsets on the AXI4-Lite bus.
`define OFS_RESET_CAUSE 8'h34
`define OFS_WDT_CTRL 8'h60
`define OFS_IRQ_STATUS 8'h64
`define OFS_IRQ_MASK 8'h68
`define OFS_VECTOR 8'h6C
// Reset-cause field positions.
`define RC_POWER_ON 0
`define RC_PIN 1
`define RC_LOW_VOLTAGE 2
`define RC_WATCHDOG 3
`define RC_DEBUGGER 4
`define RC_POWER_OFF_WAKE 5
`define RC_DEBUG_PORT_DISABLE 7
// Watchdog control field positions.
`define WC_IRQ_FLAG 7
`define WC_IRQ_ENABLE 6
`define WC_SEL_MSB 5
`define WC_TURN_OFF 4
`define WC_ENABLE 3
// Reset values.
`define RESET_CAUSE_RST 8'h00
`define WDT_CTRL_RST 8'h00
// Timing.
`define TURN_OFF_CYCLES 3'h4
`define SLOW_DIV_DEFAULT 781
`define FAST_DIV_DEFAULT 16
`define FAST_CLK_MHZ 32
`define LAST_SEL_CODE 4'h9
`define BASE_COUNT_LOG2 11
// Watchdog vector locations.
`define VEC_ONE_WORD 16'h0006
`define VEC_TWO_WORD 16'h000C
// Status bits for the interrupt output.
`define IS_TIMEOUT 0
`define IS_WDT_RESET 1
`endif

// *** rtl/tick_divider.v ***
module tick_divider #(
  parameter DIV = 16
) (
  input wire clk,
  input wire rst,
  input wire clear,
  output reg tick_ff
);
  reg [19:0] cnt_ff;

  always @(posedge clk) begin
    if (rst || clear) begin
      cnt_ff <= 20'h00000;
      tick_ff <= 1'b0;
    end else if (cnt_ff == DIV[19:0] - 20'h00001) begin
      cnt_ff <= 20'h00000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 20'h00001;
      tick_ff <= 1'b0;
    end
  end
endmodule // tick_divider

// *** rtl/sync2.v ***
module sync2 (
  input wire clk,
  input wire rst,
  input wire d,
  output reg q_ff
);
  reg meta_ff;

  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule // sync2

// *** rtl/watchdog_with_reset_cause.v ***
`include "wdt_defines.vh"
module watchdog_with_reset_cause #(
  parameter SLOW_DIV = `SLOW_DIV_DEFAULT,
  parameter FAST_DIV = `FAST_DIV_DEFAULT,
  parameter TWO_WORD_VECTORS = 0
) (
  // Clock and reset.
  input wire MCLK,
  input wire SYS_RST,
  // AXI4-Lite write address, data and response.
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read.
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Reset sources and core hooks.
  input wire POWER_ON_EVENT,
  input wire PIN_RESET_EVENT,
  input wire LOW_VOLTAGE_EVENT,
  input wire DEBUGGER_EVENT,
  input wire POWER_OFF_WAKE,
  input wire COUNTER_RESTART,
  input wire GLOBAL_IRQ_ENABLE,
  input wire IRQ_SERVICED,
  // Outputs.
  output reg WDT_IRQ_REQ,
  output reg [15:0] WDT_IRQ_VECTOR,
  output reg WDT_SYSTEM_RESET,
  output reg DEBUG_PORT_OFF,
  output reg IRQ
);
  localparam [1:0] MODE_STOP = 2'b00;
  localparam [1:0] MODE_IRQ = 2'b01;
  localparam [1:0] MODE_RST = 2'b10;
  localparam [1:0] MODE_BOTH = 2'b11;

  reg [7:0] rc_ff;
  reg [7:0] wc_ff;
  reg [2:0] off_cnt_ff;
  reg [20:0] cnt_ff;
  reg fired_ff;
  reg [1:0] ist_ff;
  reg [1:0] imask_ff;
  reg use_fast_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg aw_have_ff;
  reg w_have_ff;
  reg [7:0] nxt_rc;
  reg [7:0] nxt_wc;
  reg [20:0] limit;
  reg [31:0] rd_val;
  reg rd_ok;

  wire s_por;
  wire s_pin;
  wire s_lv;
  wire s_dbg;
  wire s_pow;
  wire tick_slow;
  wire tick_fast;
  wire [1:0] mode = {wc_ff[`WC_ENABLE], wc_ff[`WC_IRQ_ENABLE]};
  wire [3:0] sel = {wc_ff[`WC_SEL_MSB], wc_ff[2:0]};
  wire do_write = aw_have_ff && w_have_ff && !S_AXI_BVALID;
  wire do_read = S_AXI_ARVALID && S_AXI_ARREADY;
  wire wr_rc = do_write && awaddr_ff == `OFS_RESET_CAUSE && wstrb_ff[0];
  wire wr_wc = do_write && awaddr_ff == `OFS_WDT_CTRL && wstrb_ff[0];
  wire tick = use_fast_ff ? tick_fast : tick_slow;
  wire overflow = tick && (mode != MODE_STOP) && (cnt_ff >= limit);

  // Reset sources arrive from other clock domains.
  sync2 u_sync_por (.clk(MCLK), .rst(1'b0), .d(POWER_ON_EVENT), .q_ff(s_por));
  sync2 u_sync_pin (.clk(MCLK), .rst(SYS_RST), .d(PIN_RESET_EVENT), .q_ff(s_pin));
  sync2 u_sync_lv (.clk(MCLK), .rst(SYS_RST), .d(LOW_VOLTAGE_EVENT), .q_ff(s_lv));
  sync2 u_sync_dbg (.clk(MCLK), .rst(SYS_RST), .d(DEBUGGER_EVENT), .q_ff(s_dbg));
  sync2 u_sync_pow (.clk(MCLK), .rst(SYS_RST), .d(POWER_OFF_WAKE), .q_ff(s_pow));

  // Both tick sources are derived from MCLK here; the rate choice stays selectable.
  tick_divider #(.DIV(SLOW_DIV)) u_div_slow (
    .clk(MCLK), .rst(SYS_RST), .clear(1'b0), .tick_ff(tick_slow)
  );
  tick_divider #(.DIV(FAST_DIV)) u_div_fast (
    .clk(MCLK), .rst(SYS_RST), .clear(1'b0), .tick_ff(tick_fast)
  );

  always @* begin
    limit = 21'h000000;
    if (sel <= `LAST_SEL_CODE)
      limit = (21'h000001 << (`BASE_COUNT_LOG2 + sel)) - 21'h000001;
    else
      limit = 21'h1FFFFF;
  end

  // Reset-cause register. The power-on source is not gated by system reset.
  always @* begin
    nxt_rc = rc_ff;
    if (wr_rc) begin
      nxt_rc[`RC_POWER_ON] = rc_ff[`RC_POWER_ON] & wdata_ff[`RC_POWER_ON];
      nxt_rc[`RC_PIN] = rc_ff[`RC_PIN] & wdata_ff[`RC_PIN];
      nxt_rc[`RC_LOW_VOLTAGE] = rc_ff[`RC_LOW_VOLTAGE] & wdata_ff[`RC_LOW_VOLTAGE];
      nxt_rc[`RC_WATCHDOG] = rc_ff[`RC_WATCHDOG] & wdata_ff[`RC_WATCHDOG];
      nxt_rc[`RC_DEBUGGER] = rc_ff[`RC_DEBUGGER] & wdata_ff[`RC_DEBUGGER];
      nxt_rc[`RC_POWER_OFF_WAKE] = rc_ff[`RC_POWER_OFF_WAKE] & wdata_ff[`RC_POWER_OFF_WAKE];
      if (wdata_ff[`RC_DEBUG_PORT_DISABLE])
        nxt_rc[`RC_DEBUG_PORT_DISABLE] = 1'b1;
    end
    // Set wins over a clearing write in the same cycle.
    if (s_pin) nxt_rc[`RC_PIN] = 1'b1;
    if (s_lv) nxt_rc[`RC_LOW_VOLTAGE] = 1'b1;
    if (s_dbg) nxt_rc[`RC_DEBUGGER] = 1'b1;
    if (s_pow) nxt_rc[`RC_POWER_OFF_WAKE] = 1'b1;
    if (fired_ff) nxt_rc[`RC_WATCHDOG] = 1'b1;
    if (s_por) nxt_rc = 8'h01;
    nxt_rc[6] = 1'b0;
  end

  always @(posedge MCLK) begin
    if (s_por)
      rc_ff <= 8'h01;
    else if (SYS_RST && !fired_ff)
      rc_ff <= rc_ff;
    else
      rc_ff <= nxt_rc;
  end

  // Watchdog control register.
  always @* begin
    nxt_wc = wc_ff;
    if (wr_wc) begin
      nxt_wc[`WC_IRQ_ENABLE] = wdata_ff[`WC_IRQ_ENABLE];
      nxt_wc[`WC_SEL_MSB] = wdata_ff[`WC_SEL_MSB];
      nxt_wc[2:0] = wdata_ff[2:0];
      nxt_wc[`WC_TURN_OFF] = wdata_ff[`WC_TURN_OFF];
      if (wdata_ff[`WC_ENABLE])
        nxt_wc[`WC_ENABLE] = 1'b1;
      else if (wc_ff[`WC_TURN_OFF] && !rc_ff[`RC_WATCHDOG])
        nxt_wc[`WC_ENABLE] = 1'b0;
      if (wdata_ff[`WC_IRQ_FLAG])
        nxt_wc[`WC_IRQ_FLAG] = 1'b0;
    end
    if (IRQ_SERVICED && WDT_IRQ_REQ)
      nxt_wc[`WC_IRQ_FLAG] = 1'b0;
    if (off_cnt_ff == `TURN_OFF_CYCLES)
      nxt_wc[`WC_TURN_OFF] = 1'b0;
    if (rc_ff[`RC_WATCHDOG])
      nxt_wc[`WC_ENABLE] = 1'b1;
    if (overflow && mode == MODE_IRQ)
      nxt_wc[`WC_IRQ_FLAG] = 1'b1;
    if (overflow && mode == MODE_BOTH) begin
      nxt_wc[`WC_IRQ_FLAG] = 1'b1;
      nxt_wc[`WC_IRQ_ENABLE] = 1'b0;
    end
  end

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      wc_ff <= `WDT_CTRL_RST;
      off_cnt_ff <= 3'h0;
      cnt_ff <= 21'h000000;
      fired_ff <= 1'b0;
      use_fast_ff <= 1'b0;
      ist_ff <= 2'b00;
      imask_ff <= 2'b00;
    end else begin
      wc_ff <= nxt_wc;
      if (!nxt_wc[`WC_TURN_OFF] || off_cnt_ff == `TURN_OFF_CYCLES)
        off_cnt_ff <= 3'h0;
      else
        off_cnt_ff <= off_cnt_ff + 3'h1;
      if (COUNTER_RESTART || mode == MODE_STOP || overflow)
        cnt_ff <= 21'h000000;
      else if (tick)
        cnt_ff <= cnt_ff + 21'h000001;
      fired_ff <= overflow && mode == MODE_RST;
      if (do_write && awaddr_ff == `OFS_IRQ_MASK && wstrb_ff[0])
        imask_ff <= wdata_ff[1:0];
      if (do_write && awaddr_ff == `OFS_VECTOR && wstrb_ff[0])
        use_fast_ff <= wdata_ff[0];
      // Status is clear-on-read; a new event in the read cycle survives.
      ist_ff <= ((do_read && S_AXI_ARADDR == `OFS_IRQ_STATUS) ? 2'b00 : ist_ff)
        | {overflow && mode == MODE_RST, overflow && mode[0]};
    end
  end

  // Outputs. WDT_SYSTEM_RESET is one cycle; the system feeds it back on SYS_RST.
  always @(posedge MCLK) begin
    if (SYS_RST && !fired_ff) begin
      WDT_IRQ_REQ <= 1'b0;
      WDT_SYSTEM_RESET <= 1'b0;
      IRQ <= 1'b0;
      WDT_IRQ_VECTOR <= TWO_WORD_VECTORS ? `VEC_TWO_WORD : `VEC_ONE_WORD;
      DEBUG_PORT_OFF <= rc_ff[`RC_DEBUG_PORT_DISABLE];
    end else begin
      WDT_IRQ_REQ <= nxt_wc[`WC_IRQ_FLAG] && (nxt_wc[`WC_IRQ_ENABLE] || mode == MODE_BOTH)
        && GLOBAL_IRQ_ENABLE;
      WDT_SYSTEM_RESET <= fired_ff;
      IRQ <= |(ist_ff & imask_ff);
      WDT_IRQ_VECTOR <= TWO_WORD_VECTORS ? `VEC_TWO_WORD : `VEC_ONE_WORD;
      DEBUG_PORT_OFF <= nxt_rc[`RC_DEBUG_PORT_DISABLE];
    end
  end

  // AXI4-Lite slave; one write and one read outstanding.
  always @* begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      `OFS_RESET_CAUSE: rd_val = {24'h000000, rc_ff};
      `OFS_WDT_CTRL: rd_val = {24'h000000, wc_ff};
      `OFS_IRQ_STATUS: rd_val = {30'h00000000, ist_ff};
      `OFS_IRQ_MASK: rd_val = {30'h00000000, imask_ff};
      `OFS_VECTOR: rd_val = {15'h0000, (TWO_WORD_VECTORS ? `VEC_TWO_WORD : `VEC_ONE_WORD),
        use_fast_ff};
      default: begin
        rd_val = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= 2'b00;
      S_AXI_RDATA <= 32'h00000000;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      S_AXI_AWREADY <= !aw_have_ff && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= !w_have_ff && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_ff == `OFS_RESET_CAUSE || awaddr_ff == `OFS_WDT_CTRL
          || awaddr_ff == `OFS_IRQ_MASK || awaddr_ff == `OFS_VECTOR) ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (do_read) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? 2'b00 : 2'b10;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule // watchdog_with_reset_cause

// *** bench/watchdog_with_reset_cause_chk.sv ***
module watchdog_with_reset_cause_chk (
  // Clock and reset.
  input wire MCLK,
  input wire SYS_RST,
  // Watched ports.
  input wire POWER_ON_EVENT,
  input wire GLOBAL_IRQ_ENABLE,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire WDT_IRQ_REQ,
  input wire [15:0] WDT_IRQ_VECTOR,
  input wire WDT_SYSTEM_RESET,
  input wire DEBUG_PORT_OFF
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  property p_vec; WDT_IRQ_VECTOR == 16'h0006; endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_req; WDT_IRQ_REQ |-> $past(GLOBAL_IRQ_ENABLE); endproperty
  a_req: assert property (p_req) else $error("request without global enable");
  property p_pulse; WDT_SYSTEM_RESET |=> !WDT_SYSTEM_RESET; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_dbg_set; $rose(DEBUG_PORT_OFF) |-> S_AXI_BVALID || $past(S_AXI_BVALID); endproperty
  a_dbg_set: assert property (p_dbg_set) else $error("debug off without write");
  // The debug port may only come back through a power-up.
  property p_dbg_hold;
    $fell(DEBUG_PORT_OFF) |-> POWER_ON_EVENT || $past(POWER_ON_EVENT, 4);
  endproperty
  a_dbg_hold: assert property (p_dbg_hold) else $error("debug port back on");
  property p_ar; $rose(S_AXI_ARREADY) |-> $past(S_AXI_ARVALID); endproperty
  a_ar: assert property (p_ar) else $error("arready without request");
  property p_rv; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read answer late");
  property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID; endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_bdone; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_bdone: assert property (p_bdone) else $error("bvalid stuck");
  c_rst: cover property (WDT_SYSTEM_RESET);
  c_req: cover property (WDT_IRQ_REQ);
  c_dbg: cover property ($rose(DEBUG_PORT_OFF));
endmodule // watchdog_with_reset_cause_chk
bind watchdog_with_reset_cause watchdog_with_reset_cause_chk chk_u (
  .MCLK(MCLK),
  .SYS_RST(SYS_RST),
  .POWER_ON_EVENT(POWER_ON_EVENT),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY),
  .WDT_IRQ_REQ(WDT_IRQ_REQ),
  .WDT_IRQ_VECTOR(WDT_IRQ_VECTOR),
  .WDT_SYSTEM_RESET(WDT_SYSTEM_RESET),
  .DEBUG_PORT_OFF(DEBUG_PORT_OFF)
);

// *** bench/watchdog_with_reset_cause_tb.sv ***
module watchdog_with_reset_cause_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK;
  logic SYS_RST = 1;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_ARVALID = 0;
  // Ready is held high for good: a response is always taken at once.
  logic S_AXI_BREADY = 1, S_AXI_RREADY = 1;
  logic POWER_ON_EVENT = 1, PIN_RESET_EVENT = 0, LOW_VOLTAGE_EVENT = 0;
  logic DEBUGGER_EVENT = 0, POWER_OFF_WAKE = 0, COUNTER_RESTART = 0;
  logic GLOBAL_IRQ_ENABLE = 1, IRQ_SERVICED = 0;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire WDT_IRQ_REQ, WDT_SYSTEM_RESET, DEBUG_PORT_OFF, IRQ;
  wire [15:0] WDT_IRQ_VECTOR;
  int error_cnt = 0, comparisons = 0, n, i;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [7:0] ta[6] = '{8'h34, 8'h60, 8'h60, 8'h68, 8'h6C, 8'h70};
  logic [7:0] td[6] = '{8'h00, 8'h27, 8'h00, 8'h03, 8'h00, 8'h55};
  logic [7:0] te[6] = '{8'h00, 8'h27, 8'h00, 8'h03, 8'h0C, 8'h00};
  logic [1:0] tr[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

  // The fast tick runs every cycle so that the clock select shows in the overflow span.
  watchdog_with_reset_cause #(.SLOW_DIV(2), .FAST_DIV(1)) dut_u (
    .MCLK(MCLK),
    .SYS_RST(SYS_RST),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .POWER_ON_EVENT(POWER_ON_EVENT),
    .PIN_RESET_EVENT(PIN_RESET_EVENT),
    .LOW_VOLTAGE_EVENT(LOW_VOLTAGE_EVENT),
    .DEBUGGER_EVENT(DEBUGGER_EVENT),
    .POWER_OFF_WAKE(POWER_OFF_WAKE),
    .COUNTER_RESTART(COUNTER_RESTART),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .IRQ_SERVICED(IRQ_SERVICED),
    .WDT_IRQ_REQ(WDT_IRQ_REQ),
    .WDT_IRQ_VECTOR(WDT_IRQ_VECTOR),
    .WDT_SYSTEM_RESET(WDT_SYSTEM_RESET),
    .DEBUG_PORT_OFF(DEBUG_PORT_OFF),
    .IRQ(IRQ)
  );

  initial begin
    MCLK = 0;
    forever #20 MCLK = ~MCLK;
  end

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #1200000;
    error_cnt++;
    $display("watchdog span ran out");
    conclude();
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Both tasks are entered just after a rising edge.
  task wr(input logic [7:0] a, input logic [7:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
      if (S_AXI_AWREADY === 1) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY === 1) S_AXI_WVALID <= 0;
    end while (S_AXI_BVALID !== 1);
    rr = S_AXI_BRESP;
    chk("write answer", 1, n < 40);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
      if (S_AXI_ARREADY === 1) S_AXI_ARVALID <= 0;
    end while (S_AXI_RVALID !== 1);
    chk(nm, {24'h0, e}, S_AXI_RDATA);
    rr = S_AXI_RRESP;
  endtask

  // A zero selects the interrupt request, a one the system reset pulse.
  task wait_for(input int lim, input bit which);
    for (n = 0; n < lim && (which ? WDT_SYSTEM_RESET : WDT_IRQ_REQ) !== 1; n++)
      @(posedge MCLK);
  endtask

  initial begin
    repeat (8) @(posedge MCLK);
    POWER_ON_EVENT <= 0;
    repeat (12) @(posedge MCLK);
    SYS_RST <= 0;
    rd(8'h34, 8'h01, "power-on cause");
    chk("vector", 32'h00000006, WDT_IRQ_VECTOR);
    rd(8'h60, 8'h00, "control reset");
    for (i = 0; i < 6; i++) begin
      wr(ta[i], td[i]);
      chk("write resp", tr[i], rr);
      rd(ta[i], te[i], "readback");
      chk("read resp", tr[i], rr);
    end
    $display("register table done");
    wr(8'h60, 8'h40);
    // A restart a quarter of the way in must push the overflow a full span later.
    repeat (1000) @(posedge MCLK);
    COUNTER_RESTART <= 1;
    @(posedge MCLK);
    COUNTER_RESTART <= 0;
    wait_for(5000, 0);
    chk("overflow span", 1, n > 3900 && n < 4300);
    rd(8'h60, 8'hC0, "timeout flag");
    chk("irq line", 1, IRQ);
    GLOBAL_IRQ_ENABLE <= 0;
    repeat (3) @(posedge MCLK);
    chk("global gate", 0, WDT_IRQ_REQ);
    GLOBAL_IRQ_ENABLE <= 1;
    rd(8'h64, 8'h01, "irq status");
    repeat (3) @(posedge MCLK);
    chk("irq line cleared", 0, IRQ);
    IRQ_SERVICED <= 1;
    @(posedge MCLK);
    IRQ_SERVICED <= 0;
    repeat (2) @(posedge MCLK);
    rd(8'h60, 8'h40, "flag serviced");
    wr(8'h60, 8'h00);
    $display("interrupt mode done");
    wr(8'h60, 8'h08);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h08, "enable kept");
    wait_for(5000, 1);
    chk("reset pulse", 1, n < 5000);
    SYS_RST <= 1;
    repeat (3) @(posedge MCLK);
    SYS_RST <= 0;
    rd(8'h34, 8'h08, "watchdog cause");
    wr(8'h60, 8'h18);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h08, "enable held by cause");
    wr(8'h34, 8'h00);
    wr(8'h60, 8'h18);
    repeat (8) @(posedge MCLK);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h08, "late turn-off");
    wr(8'h60, 8'h18);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h00, "turned off");
    $display("reset mode done");
    wr(8'h6C, 8'h01);
    wr(8'h60, 8'h48);
    wait_for(5000, 0);
    chk("fast overflow span", 1, n > 1950 && n < 2150);
    rd(8'h60, 8'h88, "both mode flag");
    wait_for(5000, 1);
    chk("reset after irq", 1, n > 1950 && n < 2150);
    SYS_RST <= 1;
    repeat (3) @(posedge MCLK);
    SYS_RST <= 0;
    rd(8'h6C, 8'h0C, "clock select reset");
    rd(8'h34, 8'h08, "cause after both");
    wr(8'h34, 8'h00);
    wr(8'h60, 8'h18);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h00, "stopped again");
    $display("interrupt-and-reset mode done");
    {PIN_RESET_EVENT, LOW_VOLTAGE_EVENT, DEBUGGER_EVENT, POWER_OFF_WAKE} <= 4'hF;
    repeat (4) @(posedge MCLK);
    {PIN_RESET_EVENT, LOW_VOLTAGE_EVENT, DEBUGGER_EVENT, POWER_OFF_WAKE} <= 4'h0;
    repeat (4) @(posedge MCLK);
    rd(8'h34, 8'h36, "cause flags");
    wr(8'h34, 8'h80);
    rd(8'h34, 8'h80, "debug disable");
    chk("debug port off", 1, DEBUG_PORT_OFF);
    POWER_ON_EVENT <= 1;
    repeat (4) @(posedge MCLK);
    POWER_ON_EVENT <= 0;
    repeat (4) @(posedge MCLK);
    rd(8'h34, 8'h01, "power-up again");
    chk("debug port on", 0, DEBUG_PORT_OFF);
    $display("reset causes done");
    conclude();
  end
endmodule // watchdog_with_reset_cause_tb
